/* File: core/dpb_cfg.svh */
`ifndef DPB_CFG_SVH
`define DPB_CFG_SVH
`define DPB_ENTRIES 8
`define DPB_ADDR_W 32
`define DPB_LINE_BYTES 128
`define DPB_HALF_BYTES 64
`define DPB_LINE_LSB 7
`define DPB_HALF_BIT 6
`define DPB_HALF_DATA_W (`DPB_HALF_BYTES * 8)
`define DPB_NOL2_LO 32'h0C00_0000
`define DPB_NOL2_HI 32'h0FFF_FFFF
`define DPB_ALIAS_NIB 4'h1
`define DPB_GEN_W 3
`define DPB_WAIT_LIMIT 1024
`define DPB_L1_MODE_W 3
`define DPB_L1_OPER_W 3
`define DPB_L2_MODE_W 3
`define DPB_CORE_ID_W 4
`endif

/* File: core/dpb_pkg.sv */
package dpb_pkg;

   typedef enum logic [1:0]
   {
      DPB_CLS_DATA_HIT = 2'h0,
      DPB_CLS_HIT_WAIT = 2'h1,
      DPB_CLS_ADDR_HIT = 2'h2,
      DPB_CLS_MISS     = 2'h3
   } dpb_class_type;

   typedef enum logic [0:0]
   {
      DPB_ST_IDLE = 1'h0,
      DPB_ST_WAIT = 1'h1
   } dpb_state_type;

endpackage

/* File: core/dpb_line_mem.sv */
`timescale 1ns/10ps
module dpb_line_mem
#(
   parameter int ENTRIES = 8,
   parameter int HALF_W  = 512
)
(
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       wr_en,
   input  wire logic [$clog2(ENTRIES)-1:0] wr_entry,
   input  wire logic                       wr_half,
   input  wire logic [HALF_W-1:0]          wr_data,
   input  wire logic                       rd_en,
   input  wire logic [$clog2(ENTRIES)-1:0] rd_entry,
   output logic      [2*HALF_W-1:0]        rd_data_r
);

   logic [HALF_W-1:0] mem_lo [ENTRIES];
   logic [HALF_W-1:0] mem_hi [ENTRIES];

   // Storage itself is not reset; validity lives in the owner
   always_ff @(posedge clk)
   begin
      if (wr_en && !wr_half)
      begin
         mem_lo[wr_entry] <= wr_data;
      end
      if (wr_en && wr_half)
      begin
         mem_hi[wr_entry] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_data_r <= '0;
      end
      else if (rd_en)
      begin
         rd_data_r <= {mem_hi[rd_entry], mem_lo[rd_entry]};
      end
   end

endmodule // dpb_line_mem

/* File: core/dpb_prefetch_buffer.sv */
`timescale 1ns/10ps
`include "dpb_cfg.svh"
module dpb_prefetch_buffer
#(
   parameter int ENTRIES     = `DPB_ENTRIES,
   parameter int HALF_W      = `DPB_HALF_DATA_W,
   parameter int GEN_W       = `DPB_GEN_W,
   parameter int WAIT_CYCLES = `DPB_WAIT_LIMIT
)
(
   input  wire logic                                        clk,
   input  wire logic                                        rst_n,
   input  wire logic                                        acc_valid,
   input  wire logic [`DPB_ADDR_W-1:0]                      acc_addr,
   input  wire logic                                        acc_write,
   input  wire logic                                        acc_from_l2,
   input  wire logic                                        region_cacheable_bit,
   input  wire logic                                        region_prefetch_enable_bit,
   input  wire logic [`DPB_L1_MODE_W-1:0]                   l1d_size_mode_field,
   input  wire logic [`DPB_L1_OPER_W-1:0]                   l1d_freeze_operation_field,
   input  wire logic                                        l2_freeze_bit,
   input  wire logic [`DPB_L2_MODE_W-1:0]                   l2_size_mode_field,
   input  wire logic [`DPB_CORE_ID_W-1:0]                   core_id_field,
   output logic                                             acc_ready_r,
   output logic                                             cls_valid_r,
   output dpb_pkg::dpb_class_type                           cls_type_r,
   output logic                                             rsp_valid_r,
   output logic      [1:0]                                  rsp_half_mask_r,
   output logic      [2*HALF_W-1:0]                         rsp_data_r,
   output logic                                             fwd_valid_r,
   output logic      [`DPB_ADDR_W-1:0]                      fwd_addr_r,
   output logic                                             fwd_write_r,
   output logic                                             pf_req_valid_r,
   output logic      [`DPB_ADDR_W-1:0]                      pf_req_addr_r,
   output logic      [GEN_W+$clog2(ENTRIES):0]              pf_req_tag_r,
   input  wire logic                                        pf_req_ready,
   input  wire logic                                        pf_ret_valid,
   input  wire logic [GEN_W+$clog2(ENTRIES):0]              pf_ret_tag,
   input  wire logic                                        pf_ret_ok,
   input  wire logic [HALF_W-1:0]                           pf_ret_data
);

   localparam int NE  = ENTRIES;
   localparam int EW  = $clog2(NE);
   localparam int NS  = 2 * NE;
   localparam int SW  = EW + 1;
   localparam int TW  = GEN_W + SW;
   localparam int LW  = `DPB_ADDR_W - `DPB_LINE_LSB;
   localparam int TMW = $clog2(WAIT_CYCLES + 1);

   // Entry table: one stream per entry, two 64-byte slots per entry
   logic [NE-1:0]    sv_r,   sv_nxt;
   logic [LW-1:0]    base_r [NE];
   logic [LW-1:0]    base_nxt [NE];
   logic [NS-1:0]    dv_r,   dv_nxt;
   logic [NS-1:0]    os_r,   os_nxt;
   logic [NS-1:0]    pend_r, pend_nxt;
   logic [GEN_W-1:0] gen_r  [NS];
   logic [GEN_W-1:0] gen_nxt [NS];
   logic [EW-1:0]    ptr_r,  ptr_nxt;
   logic             cand_v_r, cand_v_nxt;
   logic [LW-1:0]    cand_line_r, cand_line_nxt;

   dpb_pkg::dpb_state_type st_r, st_nxt;
   logic [EW-1:0]          w_entry_r, w_entry_nxt;
   logic [LW-1:0]          w_line_r,  w_line_nxt;
   logic [1:0]             w_need_r,  w_need_nxt;
   logic [`DPB_ADDR_W-1:0] w_addr_r,  w_addr_nxt;
   logic [TMW-1:0]         wtmr_r,    wtmr_nxt;

   logic                   ready_nxt, clsv_nxt, rspv_nxt, fwdv_nxt, fwdw_nxt, pfv_nxt;
   dpb_pkg::dpb_class_type cls_nxt;
   logic [1:0]             mask_nxt;
   logic [`DPB_ADDR_W-1:0] fwda_nxt, pfa_nxt;
   logic [TW-1:0]          pft_nxt;

   // Decode of the incoming access
   logic [LW-1:0] acc_line;
   logic          acc_half;
   logic [1:0]    acc_need;
   logic          direct_ok, elig;
   logic [NE-1:0] match;
   logic          hit_v;
   logic [EW-1:0] hit_e;

   logic          mem_wr, mem_rd;
   logic [EW-1:0] mem_rd_entry;
   logic [SW-1:0] ret_slot;
   logic          pick_v;
   logic [SW-1:0] pick;

   assign acc_line = acc_addr[`DPB_ADDR_W-1:`DPB_LINE_LSB];
   assign acc_half = acc_addr[`DPB_HALF_BIT];
   assign acc_need = acc_from_l2 ? 2'h3 : {acc_half, !acc_half};
   assign ret_slot = pf_ret_tag[SW-1:0];

   // L1D requests that skip L2 reach the prefetcher directly
   assign direct_ok = !acc_from_l2
                      && ((acc_addr >= `DPB_NOL2_LO && acc_addr <= `DPB_NOL2_HI)
                          || (acc_addr > `DPB_NOL2_HI
                              && (l2_freeze_bit || l2_size_mode_field == '0)))
                      && l1d_size_mode_field != '0
                      && l1d_freeze_operation_field == '0
                      && !(acc_addr[31:28] == `DPB_ALIAS_NIB
                           && acc_addr[27:24] == core_id_field);
   assign elig = !acc_write && region_cacheable_bit && region_prefetch_enable_bit
                 && (acc_from_l2 || direct_ok);

   for (genvar e = 0; e < NE; e++)
   begin : g_match
      assign match[e] = sv_r[e] && (base_r[e] == acc_line);
   end

   always_comb
   begin
      hit_v = 1'b0;
      hit_e = '0;
      for (int e = 0; e < NE; e++)
      begin
         if (match[e] && !hit_v)
         begin
            hit_v = 1'b1;
            hit_e = EW'(e);
         end
      end
   end

   dpb_line_mem
   #(
      .ENTRIES (NE),
      .HALF_W  (HALF_W)
   )
   u_mem
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .wr_en     (mem_wr),
      .wr_entry  (ret_slot[SW-1:1]),
      .wr_half   (ret_slot[0]),
      .wr_data   (pf_ret_data),
      .rd_en     (mem_rd),
      .rd_entry  (mem_rd_entry),
      .rd_data_r (rsp_data_r)
   );

   always_comb
   begin
      logic [SW-1:0] s;
      logic [EW-1:0] ce;
      logic [1:0]    cneed;
      logic          consume;
      logic          fwd_req;
      logic [1:0]    dvp, osp, miss;
      sv_nxt        = sv_r;
      base_nxt      = base_r;
      dv_nxt        = dv_r;
      os_nxt        = os_r;
      pend_nxt      = pend_r;
      gen_nxt       = gen_r;
      ptr_nxt       = ptr_r;
      cand_v_nxt    = cand_v_r;
      cand_line_nxt = cand_line_r;
      st_nxt        = st_r;
      w_entry_nxt   = w_entry_r;
      w_line_nxt    = w_line_r;
      w_need_nxt    = w_need_r;
      w_addr_nxt    = w_addr_r;
      wtmr_nxt      = wtmr_r;
      clsv_nxt      = 1'b0;
      cls_nxt       = cls_type_r;
      rspv_nxt      = 1'b0;
      mask_nxt      = rsp_half_mask_r;
      fwdv_nxt      = 1'b0;
      fwda_nxt      = fwd_addr_r;
      fwdw_nxt      = fwd_write_r;
      pfv_nxt       = pf_req_valid_r && !pf_req_ready;
      pfa_nxt       = pf_req_addr_r;
      pft_nxt       = pf_req_tag_r;
      mem_wr        = 1'b0;
      mem_rd        = 1'b0;
      mem_rd_entry  = '0;
      s             = '0;
      ce            = '0;
      cneed         = '0;
      consume       = 1'b0;
      fwd_req       = 1'b0;
      dvp           = '0;
      osp           = '0;
      miss          = '0;
      pick_v        = 1'b0;
      pick          = '0;

      // Return only lands if the slot still waits on that generation
      if (pf_ret_valid && os_r[ret_slot] && gen_r[ret_slot] == pf_ret_tag[TW-1:SW])
      begin
         os_nxt[ret_slot] = 1'b0;
         if (pf_ret_ok)
         begin
            dv_nxt[ret_slot] = 1'b1;
            mem_wr           = 1'b1;
         end
      end

      // One slot never carries two live requests: pick skips outstanding slots
      for (int i = NS - 1; i >= 0; i--)
      begin
         if (pend_r[i] && !os_r[i] && sv_r[i/2])
         begin
            pick_v = 1'b1;
            pick   = SW'(i);
         end
      end
      if (pick_v)
      begin
         // Stalled request is dropped in favour of the newer one
         s = pf_req_tag_r[SW-1:0];
         if (pf_req_valid_r && !pf_req_ready && gen_r[s] == pf_req_tag_r[TW-1:SW])
         begin
            os_nxt[s] = 1'b0;
         end
         pfv_nxt        = 1'b1;
         pfa_nxt        = {base_r[pick[SW-1:1]], pick[0], {`DPB_HALF_BIT{1'b0}}};
         pft_nxt        = {gen_r[pick], pick};
         os_nxt[pick]   = 1'b1;
         pend_nxt[pick] = 1'b0;
      end

      unique case (st_r)
         dpb_pkg::DPB_ST_IDLE:
         begin
            if (acc_valid)
            begin
               dvp = dv_r[{hit_e, 1'b0} +: 2];
               osp = os_r[{hit_e, 1'b0} +: 2];
               miss = acc_need & ~dvp & ~osp;
               fwd_req  = 1'b1;
               fwda_nxt = acc_addr;
               fwdw_nxt = acc_write;
               if (acc_write && hit_v)
               begin
                  for (int h = 0; h < 2; h++)
                  begin
                     s = {hit_e, 1'(h)};
                     if (acc_need[h])
                     begin
                        dv_nxt[s] = 1'b0;
                        if (os_r[s])
                        begin
                           os_nxt[s]  = 1'b0;
                           gen_nxt[s] = gen_r[s] + GEN_W'(1);
                        end
                     end
                  end
               end
               else if (elig && hit_v)
               begin
                  clsv_nxt = 1'b1;
                  s = {hit_e, acc_half};
                  if (!acc_from_l2 && !dvp[!acc_half] && !osp[!acc_half])
                  begin
                     pend_nxt[s ^ SW'(1)] = 1'b1;
                  end
                  if ((acc_need & ~dvp) == '0)
                  begin
                     cls_nxt = dpb_pkg::DPB_CLS_DATA_HIT;
                     fwd_req = 1'b0;
                     consume = 1'b1;
                     ce      = hit_e;
                     cneed   = acc_need;
                  end
                  else if (miss != '0)
                  begin
                     cls_nxt = dpb_pkg::DPB_CLS_ADDR_HIT;
                     pend_nxt[{hit_e, 1'b0} +: 2] = pend_r[{hit_e, 1'b0} +: 2] | miss;
                  end
                  else
                  begin
                     cls_nxt     = dpb_pkg::DPB_CLS_HIT_WAIT;
                     fwd_req     = 1'b0;
                     st_nxt      = dpb_pkg::DPB_ST_WAIT;
                     w_entry_nxt = hit_e;
                     w_line_nxt  = acc_line;
                     w_need_nxt  = acc_need;
                     w_addr_nxt  = acc_addr;
                     wtmr_nxt    = '0;
                  end
               end
               else if (elig)
               begin
                  clsv_nxt      = 1'b1;
                  cls_nxt       = dpb_pkg::DPB_CLS_MISS;
                  cand_v_nxt    = 1'b1;
                  cand_line_nxt = acc_line;
                  // Oldest entry is reused; its old generation goes stale
                  if (cand_v_r && acc_line == LW'(cand_line_r + 1'b1))
                  begin
                     sv_nxt[ptr_r]   = 1'b1;
                     base_nxt[ptr_r] = LW'(acc_line + 1'b1);
                     ptr_nxt         = EW'(ptr_r + 1'b1);
                     for (int h = 0; h < 2; h++)
                     begin
                        s = {ptr_r, 1'(h)};
                        dv_nxt[s]   = 1'b0;
                        os_nxt[s]   = 1'b0;
                        pend_nxt[s] = 1'b1;
                        gen_nxt[s]  = gen_r[s] + GEN_W'(1);
                     end
                  end
               end
            end
         end
         dpb_pkg::DPB_ST_WAIT:
         begin
            dvp  = dv_r[{w_entry_r, 1'b0} +: 2];
            osp  = os_r[{w_entry_r, 1'b0} +: 2];
            miss = w_need_r & ~dvp & ~osp;
            fwda_nxt = w_addr_r;
            fwdw_nxt = 1'b0;
            if (!sv_r[w_entry_r] || base_r[w_entry_r] != w_line_r)
            begin
               fwd_req = 1'b1;
               st_nxt  = dpb_pkg::DPB_ST_IDLE;
            end
            else if ((w_need_r & ~dvp) == '0)
            begin
               consume = 1'b1;
               ce      = w_entry_r;
               cneed   = w_need_r;
               st_nxt  = dpb_pkg::DPB_ST_IDLE;
            end
            else if (miss != '0 || wtmr_r == TMW'(WAIT_CYCLES - 1))
            begin
               // Give up on a lost return; a late one must not land
               fwd_req = 1'b1;
               st_nxt  = dpb_pkg::DPB_ST_IDLE;
               for (int h = 0; h < 2; h++)
               begin
                  s = {w_entry_r, 1'(h)};
                  if (w_need_r[h] && os_r[s])
                  begin
                     os_nxt[s]  = 1'b0;
                     gen_nxt[s] = gen_r[s] + GEN_W'(1);
                  end
               end
            end
            else
            begin
               wtmr_nxt = TMW'(wtmr_r + 1'b1);
            end
         end
      endcase

      if (consume)
      begin
         mem_rd       = 1'b1;
         mem_rd_entry = ce;
         rspv_nxt     = 1'b1;
         mask_nxt     = cneed;
         dv_nxt[{ce, 1'b0} +: 2] = dv_nxt[{ce, 1'b0} +: 2] & ~cneed;
         // Drained entry steps its stream to the next line
         if (dv_nxt[{ce, 1'b0} +: 2] == '0 && os_nxt[{ce, 1'b0} +: 2] == '0
             && pend_nxt[{ce, 1'b0} +: 2] == '0)
         begin
            base_nxt[ce] = LW'(base_r[ce] + 1'b1);
            pend_nxt[{ce, 1'b0} +: 2] = 2'h3;
         end
      end
      if (fwd_req)
      begin
         fwdv_nxt = 1'b1;
      end
      ready_nxt = (st_nxt == dpb_pkg::DPB_ST_IDLE);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sv_r        <= '0;
         dv_r        <= '0;
         os_r        <= '0;
         pend_r      <= '0;
         ptr_r       <= '0;
         cand_v_r    <= 1'b0;
         cand_line_r <= '0;
         for (int i = 0; i < NE; i++)
         begin
            base_r[i] <= '0;
         end
         for (int i = 0; i < NS; i++)
         begin
            gen_r[i] <= '0;
         end
         st_r            <= dpb_pkg::DPB_ST_IDLE;
         w_entry_r       <= '0;
         w_line_r        <= '0;
         w_need_r        <= '0;
         w_addr_r        <= '0;
         wtmr_r          <= '0;
         acc_ready_r     <= 1'b0;
         cls_valid_r     <= 1'b0;
         cls_type_r      <= dpb_pkg::DPB_CLS_MISS;
         rsp_valid_r     <= 1'b0;
         rsp_half_mask_r <= '0;
         fwd_valid_r     <= 1'b0;
         fwd_addr_r      <= '0;
         fwd_write_r     <= 1'b0;
         pf_req_valid_r  <= 1'b0;
         pf_req_addr_r   <= '0;
         pf_req_tag_r    <= '0;
      end
      else
      begin
         sv_r            <= sv_nxt;
         base_r          <= base_nxt;
         dv_r            <= dv_nxt;
         os_r            <= os_nxt;
         pend_r          <= pend_nxt;
         gen_r           <= gen_nxt;
         ptr_r           <= ptr_nxt;
         cand_v_r        <= cand_v_nxt;
         cand_line_r     <= cand_line_nxt;
         st_r            <= st_nxt;
         w_entry_r       <= w_entry_nxt;
         w_line_r        <= w_line_nxt;
         w_need_r        <= w_need_nxt;
         w_addr_r        <= w_addr_nxt;
         wtmr_r          <= wtmr_nxt;
         acc_ready_r     <= ready_nxt;
         cls_valid_r     <= clsv_nxt;
         cls_type_r      <= cls_nxt;
         rsp_valid_r     <= rspv_nxt;
         rsp_half_mask_r <= mask_nxt;
         fwd_valid_r     <= fwdv_nxt;
         fwd_addr_r      <= fwda_nxt;
         fwd_write_r     <= fwdw_nxt;
         pf_req_valid_r  <= pfv_nxt;
         pf_req_addr_r   <= pfa_nxt;
         pf_req_tag_r    <= pft_nxt;
      end
   end

endmodule // dpb_prefetch_buffer

/* File: verif/dpb_mem_model.sv */
`timescale 1ns/10ps
module dpb_mem_model
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        hold,
   input  wire logic        fail,
   input  wire logic        drop,
   input  wire logic        stall,
   input  wire logic        pf_req_valid_r,
   input  wire logic [31:0] pf_req_addr_r,
   input  wire logic [6:0]  pf_req_tag_r,
   output logic             pf_req_ready,
   output logic             pf_ret_valid,
   output logic [6:0]       pf_ret_tag,
   output logic             pf_ret_ok,
   output logic [511:0]     pf_ret_data
);
   logic [38:0] q[$];
   logic [38:0] e;
   // Stalling lets a newer request overtake a held one
   assign pf_req_ready = !stall;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q.delete();
         pf_ret_valid <= 1'h0;
         pf_ret_tag <= '0;
         pf_ret_ok <= 1'h0;
         pf_ret_data <= '0;
      end
      else
      begin
         if (pf_req_valid_r && pf_req_ready)
            q.push_back({pf_req_tag_r, pf_req_addr_r});
         pf_ret_valid <= 1'h0;
         // Idle data toggles so stale bits never look valid
         pf_ret_data <= ~pf_ret_data;
         if (!hold && q.size() != 0)
         begin
            e = q.pop_front();
            pf_ret_valid <= !drop;
            pf_ret_tag <= e[38:32];
            pf_ret_ok <= !fail;
            pf_ret_data <= {16{e[31:0]}};
         end
      end
   end
endmodule // dpb_mem_model

/* File: verif/dpb_props.sv */
`timescale 1ns/10ps
module dpb_props
#(
   parameter int WAIT_CYCLES = 1024
)
(
   input wire logic                   clk,
   input wire logic                   rst_n,
   input wire logic                   acc_valid,
   input wire logic [31:0]            acc_addr,
   input wire logic                   acc_write,
   input wire logic                   acc_from_l2,
   input wire logic                   region_cacheable_bit,
   input wire logic                   acc_ready_r,
   input wire logic                   cls_valid_r,
   input wire dpb_pkg::dpb_class_type cls_type_r,
   input wire logic                   rsp_valid_r,
   input wire logic [1:0]             rsp_half_mask_r,
   input wire logic                   fwd_valid_r,
   input wire logic                   fwd_write_r
);
   logic        take;
   logic [11:0] wait_cnt_r;
   assign take = acc_valid && acc_ready_r;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         wait_cnt_r <= 12'h0;
      else
         wait_cnt_r <= acc_ready_r ? 12'h0 : wait_cnt_r + 12'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_hit_serve: assert property (cls_valid_r && cls_type_r == dpb_pkg::DPB_CLS_DATA_HIT
      |-> rsp_valid_r && !fwd_valid_r) else $error("data hit not served");
   a_wait_hold: assert property (cls_valid_r && cls_type_r == dpb_pkg::DPB_CLS_HIT_WAIT
      |-> !acc_ready_r && !rsp_valid_r && !fwd_valid_r) else $error("wait not held");
   a_fwd_class: assert property (cls_valid_r && cls_type_r[1]
      |-> fwd_valid_r && !rsp_valid_r) else $error("address hit or miss not forwarded");
   a_write_fwd: assert property (take && acc_write
      |=> fwd_valid_r && fwd_write_r && !cls_valid_r) else $error("write not forwarded");
   a_no_cache: assert property (take && !acc_write && !region_cacheable_bit
      |=> fwd_valid_r && !cls_valid_r) else $error("uncached read classified");
   a_l2_mask: assert property (take && acc_from_l2 ##1 rsp_valid_r
      |-> rsp_half_mask_r == 2'h3) else $error("l2 mask wrong");
   a_l1_mask: assert property (take && !acc_from_l2 ##1 rsp_valid_r
      |-> rsp_half_mask_r == ($past(acc_addr[6]) ? 2'h2 : 2'h1)) else $error("l1d mask wrong");
   a_wait_bound: assert property (wait_cnt_r <= WAIT_CYCLES + 4)
      else $error("access held too long");
endmodule // dpb_props
bind dpb_prefetch_buffer dpb_props #(.WAIT_CYCLES(WAIT_CYCLES)) u_props (.*);

/* File: verif/tb.sv */
`timescale 1ns/10ps
module tb;
   logic clk, rst_n, acc_valid, acc_write, acc_from_l2, hold, fail, drop, stall;
   logic region_cacheable_bit, region_prefetch_enable_bit, l2_freeze_bit;
   logic [2:0] l1d_size_mode_field, l1d_freeze_operation_field, l2_size_mode_field;
   logic [3:0] core_id_field;
   logic [31:0] acc_addr, fwd_addr_r, pf_req_addr_r;
   logic acc_ready_r, cls_valid_r, rsp_valid_r, fwd_valid_r, fwd_write_r;
   logic pf_req_valid_r, pf_req_ready, pf_ret_valid, pf_ret_ok;
   dpb_pkg::dpb_class_type cls_type_r;
   logic [1:0] rsp_half_mask_r;
   logic [1023:0] rsp_data_r;
   logic [6:0] pf_req_tag_r, pf_ret_tag;
   logic [511:0] pf_ret_data;
   int errors, samples_checked, cycles;
   dpb_prefetch_buffer #(.WAIT_CYCLES(16)) uut (.*);
   dpb_mem_model u_mem (.*);
   always #20 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(string n, logic [1039:0] e, logic [1039:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Idle cycle first so acc_valid never changes twice in one step
   task automatic acc(logic [31:0] a, logic w, logic l2);
      tick(1);
      while (acc_ready_r !== 1'h1)
         tick(1);
      acc_addr = a;
      acc_write = w;
      acc_from_l2 = l2;
      acc_valid = 1'h1;
      tick(1);
      acc_valid = 1'h0;
   endtask
   task automatic wt(logic f, int n);
      while (n > 0 && (f ? fwd_valid_r : rsp_valid_r) !== 1'h1)
      begin
         tick(1);
         n--;
      end
   endtask
   task automatic cfg(logic [11:0] c);
      {region_cacheable_bit, region_prefetch_enable_bit, l1d_size_mode_field,
         l1d_freeze_operation_field, l2_freeze_bit, l2_size_mode_field} = c;
   endtask
   function automatic logic [1023:0] ln(logic [31:0] a);
      return {{16{a + 32'h40}}, {16{a}}};
   endfunction
   // Two adjacent misses open a stream two lines on
   task automatic mk(logic [31:0] b, logic l2);
      acc(b, 1'h0, l2);
      chk("miss", {3'h7, b}, {cls_valid_r, cls_type_r, fwd_addr_r});
      acc(b + 32'h80, 1'h0, l2);
      tick(6);
   endtask
   task automatic t_hit();
      mk(32'h8000_0000, 1'h1);
      acc(32'h8000_0100, 1'h0, 1'h1);
      chk("l2 hit", {2'h3, 2'h0, 2'h3, ln(32'h8000_0100)},
         {rsp_valid_r, cls_valid_r, cls_type_r, rsp_half_mask_r, rsp_data_r});
   endtask
   task automatic t_wait();
      hold = 1'h1;
      mk(32'h0C20_0000, 1'h0);
      acc(32'h0C20_0140, 1'h0, 1'h0);
      chk("wait", 4'hA, {cls_valid_r, cls_type_r, acc_ready_r});
      hold = 1'h0;
      wt(1'h0, 12);
      chk("wait data", {3'h6, ln(32'h0C20_0100)},
         {rsp_valid_r, rsp_half_mask_r, rsp_data_r});
   endtask
   task automatic t_fail();
      fail = 1'h1;
      mk(32'h0C21_0000, 1'h0);
      fail = 1'h0;
      acc(32'h0C21_0100, 1'h0, 1'h0);
      chk("fail", {3'h6, 32'h0C21_0100},
         {fwd_valid_r, cls_type_r, fwd_addr_r});
   endtask
   task automatic t_drop();
      drop = 1'h1;
      mk(32'h0C22_0000, 1'h0);
      acc(32'h0C22_0100, 1'h0, 1'h0);
      drop = 1'h0;
      wt(1'h1, 24);
      chk("lost", {1'h1, 32'h0C22_0100}, {fwd_valid_r, fwd_addr_r});
   endtask
   task automatic t_write();
      mk(32'h0C23_0000, 1'h0);
      acc(32'h0C23_0100, 1'h0, 1'h0);
      chk("l1 hit", 5'h11, {rsp_valid_r, cls_type_r, rsp_half_mask_r});
      // High half still holds data, so only the write can empty it
      acc(32'h0C23_0140, 1'h1, 1'h0);
      chk("write", 2'h3, {fwd_valid_r, fwd_write_r});
      acc(32'h0C23_0140, 1'h0, 1'h0);
      chk("after write", 3'h6, {cls_valid_r, cls_type_r});
   endtask
   // Held request is overtaken; its slot ends empty
   task automatic t_stall();
      stall = 1'h1;
      mk(32'h0C24_0000, 1'h0);
      stall = 1'h0;
      acc(32'h0C24_0100, 1'h0, 1'h0);
      chk("collide", 3'h6, {cls_valid_r, cls_type_r});
   endtask
   task automatic t_elig();
      logic [44:0] t [11] = '{{12'hC81, 32'h0C10_0000, 1'h1}, {12'h481, 32'h0C10_1000, 1'h0},
         {12'h881, 32'h0C10_2000, 1'h0}, {12'hC01, 32'h0C10_3000, 1'h0},
         {12'hC91, 32'h0C10_4000, 1'h0}, {12'hC81, 32'h2000_0000, 1'h0},
         {12'hC89, 32'h2000_1000, 1'h1}, {12'hC80, 32'h2000_2000, 1'h1},
         {12'hC89, 32'h1300_0000, 1'h0}, {12'hC81, 32'h0FFF_FF80, 1'h1},
         {12'hC81, 32'h0BFF_FF80, 1'h0}};
      foreach (t[i])
      begin
         cfg(t[i][44:33]);
         acc(t[i][32:1], 1'h0, 1'h0);
         chk("eligible", {1'h1, t[i][0]},
            {fwd_valid_r, cls_valid_r});
      end
   endtask
   initial
   begin
      clk = 1'h0;
      rst_n = 1'h0;
      acc_valid = 1'h0;
      acc_addr = '0;
      acc_write = 1'h0;
      acc_from_l2 = 1'h0;
      hold = 1'h0;
      fail = 1'h0;
      drop = 1'h0;
      stall = 1'h0;
      core_id_field = 4'h3;
      cfg(12'hC81);
      tick(5);
      rst_n = 1'h1;
      t_hit();
      t_wait();
      t_fail();
      t_drop();
      t_write();
      t_stall();
      t_elig();
      finish_test();
   end
endmodule // tb
